// >>> per_pkg.sv
package per_pkg;

   // ****************************************
   // Sizes
   // ****************************************
   localparam int GEN_COUNT = 34;
   localparam int SHP_COUNT = 24;
   localparam int CHAN_COUNT = 22;
   localparam int PIN_GEN_COUNT = 18;
   localparam int FILT_LEN = 3;
   localparam int ADDR_W = 10;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [9:0] BUSY_OFS = 10'h000;
   localparam logic [9:0] SWEVT_OFS = 10'h010;
   localparam logic [9:0] CHANNEL_SOURCE_SELECT_BASE = 10'h100;
   localparam logic [9:0] EVS_BASE = 10'h200;
   localparam logic [9:0] VERSION_OFS = 10'h3F8;
   localparam logic [9:0] PARAM_OFS = 10'h3FC;

   // ****************************************
   // Field layouts
   // ****************************************
   localparam int EVENT_SELECT_FIELD_LSB = 0;
   localparam int EVENT_SELECT_FIELD_W = 6;
   localparam int SMX_BIT = 8;
   localparam int SEL_SMX = 6;
   localparam int SEL_W = 7;
   localparam int EVR_BIT = 0;
   localparam int EVF_BIT = 1;
   localparam int IGF_BIT = 2;
   localparam int SHP_W = 3;
   localparam int BUSY_W = 16;
   localparam int BUSY_FIXED_LSB = 16;

   // ****************************************
   // Reset and fixed values
   // ****************************************
   localparam logic [15:0] BUSY_RST = 16'hFFFF;
   localparam logic [5:0] BUSY_FIXED = 6'h3F;
   localparam logic [6:0] CHANNEL_SOURCE_SELECT_RST = 7'h00;
   localparam logic [2:0] EVS_RST = 3'h0;
   localparam logic [31:0] VERSION_VAL = 32'h00000100;

endpackage

// >>> per_shaper.sv
`timescale 1ns/100ps
`default_nettype none

module per_shaper
#(
   parameter int FILT_LEN = per_pkg::FILT_LEN
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Level and settings
   input wire logic din,
   input wire logic rise_en,
   input wire logic fall_en,
   input wire logic filt_en,
   // Shaped event
   output logic evt
);

   localparam int CNT_W = $clog2(FILT_LEN);

   typedef struct packed
   {
      logic flt;
      logic prev;
      logic [CNT_W-1:0] cnt;
   } per_shp_s;

   per_shp_s st;
   per_shp_s nx;

   generate
      if (FILT_LEN < 2 || FILT_LEN > 256)
      begin : g_bad
         $error("per_shaper: FILT_LEN out of range");
      end
   endgenerate

   // ****************************************
   // Filter and edge detect
   // ****************************************
   always_comb
   begin
      nx = st;
      nx.prev = st.flt;
      if (!filt_en)
      begin
         nx.flt = din;
         nx.cnt = '0;
      end
      else if (din == st.flt)
      begin
         nx.cnt = '0;
      end
      else if (st.cnt == CNT_W'(FILT_LEN - 1))
      begin
         nx.flt = din;
         nx.cnt = '0;
      end
      else
      begin
         nx.cnt = st.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         st <= '0;
      else
         st <= nx;
   end

   assign evt = (rise_en && st.flt && !st.prev) || (fall_en && !st.flt && st.prev);

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   a_rise_detect:
   assert property ((!filt_en && rise_en && din && !st.flt) ##1 rise_en |-> evt)
      else $error("rising edge not detected");

   a_fall_detect:
   assert property ((!filt_en && fall_en && !din && st.flt) ##1 fall_en |-> evt)
      else $error("falling edge not detected");

   a_edge_disabled:
   assert property (!rise_en && !fall_en |-> !evt)
      else $error("event with both edges disabled");

   a_glitch_blocked:
   assert property (filt_en && din != st.flt && st.cnt == '0 |=> st.flt == $past(st.flt))
      else $error("filter passed a one cycle glitch");

   a_filter_bypass:
   assert property (!filt_en |=> st.flt == $past(din))
      else $error("bypassed filter delayed the level");

endmodule

`default_nettype wire

// >>> per_router.sv
// Behaviour
// - Each channel's select register picks the generator named by its event select field.
// - With the software select bit at 1 the channel takes the software event only.
// - With the software select bit at 0 the chosen generator drives the channel.
// - A shaper reports a rising edge only while its rise enable bit is 1.
// - A shaper reports a falling edge only while its fall enable bit is 1.
// - A shaper filters glitches on its input while its filter bit is 1, else bypasses.
// - There are 34 generators, 24 shapers and 22 channels.
// - The busy status register resets to 0x003FFFFF: bits 15:0 to 0xFFFF and its bits 21:16 read 0x3F.
// - The selected event is passed on to the channel's fixed user action.
// - Events 15 to 0 are the sixteen pin change events, each shaped.
// - Events 16 and 17 are two generic clocks, each shaped.
// - Events 18 to 23 are six timer outputs, each shaped.
// - Events 24 to 33 come from comparators, clock, PWM and decoders, unshaped.
// - Channels 0 to 21 drive fixed actions in converters, DMA, PWM, decoders, timers.
// - All registers and logic run on the high-speed bus clock.
//
// Our own choice: the strobed register port.

`timescale 1ns/100ps
`default_nettype none

module per_router
#(
   parameter int GEN_COUNT = per_pkg::GEN_COUNT,
   parameter int SHP_COUNT = per_pkg::SHP_COUNT,
   parameter int CHAN_COUNT = per_pkg::CHAN_COUNT,
   parameter int FILT_LEN = per_pkg::FILT_LEN
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Register port
   input wire logic [per_pkg::ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata,
   // Event generators
   input wire logic [GEN_COUNT-1:0] gen_in,
   // Channel triggers
   output logic [CHAN_COUNT-1:0] trig_out
);

   localparam int PIN_N = per_pkg::PIN_GEN_COUNT;
   localparam int EW = per_pkg::EVENT_SELECT_FIELD_W;
   localparam logic [5:0] GEN_LIM = 6'(GEN_COUNT);
   localparam logic [5:0] CHAN_LIM = 6'(CHAN_COUNT);
   localparam logic [5:0] SHP_LIM = 6'(SHP_COUNT);
   localparam logic [5:0] BUSY_LIM = 6'(per_pkg::BUSY_W);

   // ****************************************
   // Parameter check
   // ****************************************
   generate
      // Six bit select field: value 63 must stay free to mean no generator
      if (GEN_COUNT > 63)
      begin : g_bad_gen
         $error("per_router: generator count above 63");
      end
      // Every synchronised pin input needs a shaper
      if (SHP_COUNT > GEN_COUNT || SHP_COUNT < PIN_N)
      begin : g_bad_shp
         $error("per_router: shaper count out of range");
      end
      if (CHAN_COUNT > 32 || CHAN_COUNT < 1)
      begin : g_bad_chan
         $error("per_router: channel count out of range");
      end
   endgenerate

   // ****************************************
   // State
   // ****************************************
   typedef struct packed
   {
      logic [PIN_N-1:0] sync1;
      logic [PIN_N-1:0] sync2;
      logic [CHAN_COUNT-1:0][per_pkg::SEL_W-1:0] sel;
      logic [SHP_COUNT-1:0][per_pkg::SHP_W-1:0] shp;
      logic [per_pkg::BUSY_W-1:0] busy;
      logic [CHAN_COUNT-1:0] trig;
      logic [31:0] rdata;
   } per_state_s;

   per_state_s st;
   per_state_s nx;

   logic [GEN_COUNT-1:0] ev_all;
   logic [SHP_COUNT-1:0] shp_din;
   logic [CHAN_COUNT-1:0] sw_hit;
   logic [5:0] idx;
   logic channel_source_select_hit;
   logic evs_hit;
   logic [31:0] busy_word;
   logic [31:0] param_word;

   // ****************************************
   // Address decode
   // ****************************************
   assign idx = addr[7:2];

   assign channel_source_select_hit = addr[9:8] == per_pkg::CHANNEL_SOURCE_SELECT_BASE[9:8] && addr[1:0] == 2'h0
                     && idx < CHAN_LIM;

   assign evs_hit = addr[9:8] == per_pkg::EVS_BASE[9:8] && addr[1:0] == 2'h0
                    && idx < SHP_LIM;

   assign sw_hit = (wr_en && addr == per_pkg::SWEVT_OFS) ? wdata[CHAN_COUNT-1:0] : '0;

   // Upper busy field is hard wired
   assign busy_word = {{(32 - per_pkg::BUSY_FIXED_LSB - 6){1'b0}}, per_pkg::BUSY_FIXED,
                       st.busy};

   assign param_word = {8'h00, 8'(CHAN_COUNT), 8'(SHP_COUNT), 8'(GEN_COUNT)};

   // ****************************************
   // Generators and shapers
   // ****************************************
   generate
      for (genvar g = 0; g < GEN_COUNT; g++)
      begin : g_gen
         if (g < SHP_COUNT)
         begin : g_shaped
            if (g < PIN_N)
            begin : g_pin
               // Pins and generic clocks are asynchronous
               assign shp_din[g] = st.sync2[g];
            end
            else
            begin : g_local
               assign shp_din[g] = gen_in[g];
            end

            per_shaper
            #(
               .FILT_LEN(FILT_LEN)
            )
            u_shaper
            (
               .core_clk(core_clk),
               .rstn(rstn),
               .din(shp_din[g]),
               .rise_en(st.shp[g][per_pkg::EVR_BIT]),
               .fall_en(st.shp[g][per_pkg::EVF_BIT]),
               .filt_en(st.shp[g][per_pkg::IGF_BIT]),
               .evt(ev_all[g])
            );
         end
         else
         begin : g_direct
            assign ev_all[g] = gen_in[g];
         end
      end
   endgenerate

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      nx = st;
      nx.sync1 = gen_in[PIN_N-1:0];
      nx.sync2 = st.sync1;
      nx.rdata = '0;

      // Register writes
      if (wr_en && channel_source_select_hit)
      begin
         nx.sel[idx] = {wdata[per_pkg::SMX_BIT], wdata[per_pkg::EVENT_SELECT_FIELD_LSB +: EW]};
         if (idx < BUSY_LIM)
         begin
            nx.busy[idx[3:0]] = 1'b0;
         end
      end
      if (wr_en && evs_hit)
      begin
         nx.shp[idx] = wdata[per_pkg::SHP_W-1:0];
      end

      // Channel routing
      for (int c = 0; c < CHAN_COUNT; c++)
      begin
         if (st.sel[c][per_pkg::SEL_SMX])
         begin
            nx.trig[c] = sw_hit[c];
         end
         else if (st.sel[c][EW-1:0] < GEN_LIM)
         begin
            nx.trig[c] = ev_all[st.sel[c][EW-1:0]];
         end
         else
         begin
            nx.trig[c] = 1'b0;
         end
      end

      // Register reads
      if (rd_en)
      begin
         if (addr == per_pkg::BUSY_OFS)
         begin
            nx.rdata = busy_word;
         end
         else if (channel_source_select_hit)
         begin
            nx.rdata[per_pkg::SMX_BIT] = st.sel[idx][per_pkg::SEL_SMX];
            nx.rdata[per_pkg::EVENT_SELECT_FIELD_LSB +: EW] = st.sel[idx][EW-1:0];
         end
         else if (evs_hit)
         begin
            nx.rdata[per_pkg::SHP_W-1:0] = st.shp[idx];
         end
         else if (addr == per_pkg::VERSION_OFS)
         begin
            nx.rdata = per_pkg::VERSION_VAL;
         end
         else if (addr == per_pkg::PARAM_OFS)
         begin
            nx.rdata = param_word;
         end
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st <= '0;
         st.busy <= per_pkg::BUSY_RST;
      end
      else
      begin
         st <= nx;
      end
   end

   assign rdata = st.rdata;
   assign trig_out = st.trig;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   sequence s_sel_write;
      wr_en && channel_source_select_hit;
   endsequence

   sequence s_same_read;
      rd_en && addr == $past(addr);
   endsequence

   sequence s_param_read;
      rd_en && addr == per_pkg::PARAM_OFS;
   endsequence

   a_busy_fixed:
   assert property (rd_en && addr == per_pkg::BUSY_OFS
                    |=> rdata[per_pkg::BUSY_FIXED_LSB +: 6] == per_pkg::BUSY_FIXED)
      else $error("busy upper field not 0x3F");

   a_sel_readback:
   assert property (s_sel_write ##1 s_same_read
                    |=> rdata[per_pkg::EVENT_SELECT_FIELD_LSB +: EW] == $past(wdata[per_pkg::EVENT_SELECT_FIELD_LSB +: EW], 2))
      else $error("select field read back wrong");

   a_busy_readback:
   assert property (rd_en && addr == per_pkg::BUSY_OFS
                    |=> rdata[per_pkg::BUSY_W-1:0] == $past(st.busy) && rdata[31:22] == '0)
      else $error("busy status read back wrong");

   a_param_read:
   assert property (s_param_read |=> rdata[7:0] == 8'(GEN_COUNT)
                    && rdata[15:8] == 8'(SHP_COUNT) && rdata[23:16] == 8'(CHAN_COUNT))
      else $error("parameter word wrong");

   generate
      for (genvar c = 0; c < CHAN_COUNT; c++)
      begin : g_chk
         a_sw_drives_chan:
         assert property (st.sel[c][per_pkg::SEL_SMX] && sw_hit[c] |=> trig_out[c])
            else $error("software event not routed");

         a_sw_masks_gen:
         assert property (st.sel[c][per_pkg::SEL_SMX] && !sw_hit[c] |=> !trig_out[c])
            else $error("generator leaked through software select");

         a_gen_drives_chan:
         assert property (!st.sel[c][per_pkg::SEL_SMX] && st.sel[c][EW-1:0] < GEN_LIM
                          |=> trig_out[c] == $past(ev_all[st.sel[c][EW-1:0]]))
            else $error("selected generator not routed");

         a_none_selected:
         assert property (!st.sel[c][per_pkg::SEL_SMX] && st.sel[c][EW-1:0] >= GEN_LIM
                          |=> !trig_out[c])
            else $error("event on channel with no generator");

         a_sel_stored:
         assert property (wr_en && channel_source_select_hit && idx == 6'(c)
                          |=> st.sel[c][per_pkg::SEL_SMX] == $past(wdata[per_pkg::SMX_BIT])
                          && st.sel[c][EW-1:0] == $past(wdata[per_pkg::EVENT_SELECT_FIELD_LSB +: EW]))
            else $error("select write not stored");

         a_direct_gen:
         assert property (!st.sel[c][per_pkg::SEL_SMX] && st.sel[c][EW-1:0] >= SHP_LIM
                          && st.sel[c][EW-1:0] < GEN_LIM
                          |=> trig_out[c] == $past(gen_in[st.sel[c][EW-1:0]]))
            else $error("unshaped generator not passed straight");
      end
   endgenerate

   generate
      for (genvar s = 0; s < SHP_COUNT; s++)
      begin : g_shp_chk
         a_shp_stored:
         assert property (wr_en && evs_hit && idx == 6'(s)
                          |=> st.shp[s] == $past(wdata[per_pkg::SHP_W-1:0]))
            else $error("shaper write not stored");

         a_shp_readback:
         assert property (wr_en && evs_hit && idx == 6'(s) ##1 s_same_read
                          |=> rdata[per_pkg::SHP_W-1:0] == $past(wdata[per_pkg::SHP_W-1:0], 2))
            else $error("shaper config read back wrong");
      end
   endgenerate

   generate
      for (genvar p = 0; p < PIN_N; p++)
      begin : g_pin_chk
         a_pin_sync_high:
         assert property (gen_in[p] |-> ##2 st.sync2[p])
            else $error("high pin level not through two flops");

         a_pin_sync_low:
         assert property (!gen_in[p] |-> ##2 !st.sync2[p])
            else $error("low pin level not through two flops");
      end
   endgenerate

endmodule

`default_nettype wire

// >>> per_gen_model.sv
`timescale 1ns/100ps
`default_nettype none

module per_gen_model
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Stimulus from the bench
   input wire logic [23:0] lvl,
   input wire logic [9:0] fire,
   input wire logic clr,
   // Router side
   input wire logic [21:0] trig_out,
   output logic [33:0] gen_in
);
   int hits [22];

   // ****************************************
   // Sources: held levels, then one-cycle pulses
   // ****************************************
   always_ff @(posedge core_clk or negedge rstn)
      if (!rstn)
         gen_in <= '0;
      else
         gen_in <= {fire, lvl};

   // ****************************************
   // Users: count cycles with the trigger high
   // ****************************************
   always @(posedge core_clk)
   begin
      for (int c = 0; c < 22; c++)
      begin
         hits[c] <= clr ? 0 : hits[c] + (trig_out[c] === 1'b1 ? 1 : 0);
      end
   end
endmodule

`default_nettype wire

// >>> testbench.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end

module testbench;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [9:0] addr = '0;
   logic [31:0] wdata = '0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [31:0] rdata;
   logic [33:0] gen_in;
   logic [21:0] trig_out;
   logic [23:0] lvl = '0;
   logic [9:0] fire = '0;
   logic clr = 1'b0;
   int bad_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [31:0] d;

   per_router per_router_inst (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .gen_in(gen_in), .trig_out(trig_out));
   per_gen_model per_gen_model_inst (.core_clk(core_clk), .rstn(rstn), .lvl(lvl), .fire(fire),
      .clr(clr), .trig_out(trig_out), .gen_in(gen_in));

   initial
   begin
      forever #2 core_clk = ~core_clk;
   end

   // ****************************************
   // Bus and source tasks
   // ****************************************
   // Bus tasks start right after a rising edge and end on one
   task automatic wr(input logic [9:0] a, input logic [31:0] v);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge core_clk);
      wr_en <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [9:0] a, output logic [31:0] v);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge core_clk);
      rd_en <= 1'b0;
      @(posedge core_clk);
      v = rdata;
   endtask

   // Write then read the same address with no gap
   task automatic wr_rd(input logic [9:0] a, input logic [31:0] v, output logic [31:0] r);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge core_clk);
      wr_en <= 1'b0;
      rd_en <= 1'b1;
      @(posedge core_clk);
      rd_en <= 1'b0;
      @(posedge core_clk);
      r = rdata;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic clear_hits;
      @(posedge core_clk);
      clr <= 1'b1;
      @(posedge core_clk);
      clr <= 1'b0;
   endtask

   task automatic fire_gen(input int i);
      @(posedge core_clk);
      fire[i] <= 1'b1;
      @(posedge core_clk);
      fire[i] <= 1'b0;
      wait_cyc(6);
   endtask

   task automatic pulse_lvl(input int g, input int width);
      @(posedge core_clk);
      lvl[g] <= 1'b1;
      wait_cyc(width);
      lvl[g] <= 1'b0;
      wait_cyc(12);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs;
      rd(per_pkg::BUSY_OFS, d);
      `CHK("busy after reset", 32'h003FFFFF, d)
      rd(per_pkg::CHANNEL_SOURCE_SELECT_BASE + 10'h004, d);
      `CHK("select reset", 32'h00000000, d)
      rd(per_pkg::EVS_BASE + 10'h008, d);
      `CHK("shaper reset", 32'h00000000, d)
      rd(10'h080, d);
      `CHK("unmapped read", 32'h00000000, d)
      rd(per_pkg::PARAM_OFS, d);
      `CHK("params", 32'h00161822, d)
      rd(per_pkg::VERSION_OFS, d);
      `CHK("version", per_pkg::VERSION_VAL, d)
      rd(per_pkg::SWEVT_OFS, d);
      `CHK("write only reads zero", 32'h00000000, d)
      rd(per_pkg::CHANNEL_SOURCE_SELECT_BASE + 10'h058, d);
      `CHK("select past last channel", 32'h00000000, d)
      wr_rd(per_pkg::CHANNEL_SOURCE_SELECT_BASE + 10'h004, 32'hFFFFFFC5, d);
      `CHK("select readback", 32'h00000105, d)
      wr_rd(per_pkg::EVS_BASE + 10'h004, 32'hFFFFFFFF, d);
      `CHK("shaper readback", 32'h00000007, d)
      rd(per_pkg::BUSY_OFS, d);
      `CHK("busy fixed field", 32'h003FFFFD, d)
   endtask

   task automatic t_reset;
      rstn <= 1'b0;
      wait_cyc(3);
      rstn <= 1'b1;
      rd(per_pkg::BUSY_OFS, d);
      `CHK("busy after second reset", 32'h003FFFFF, d)
      rd(per_pkg::CHANNEL_SOURCE_SELECT_BASE + 10'h004, d);
      `CHK("select after second reset", 32'h00000000, d)
      `CHK("triggers after second reset", 22'h000000, trig_out)
   endtask

   task automatic t_route;
      for (int c = 0; c < 22; c++)
         wr(per_pkg::CHANNEL_SOURCE_SELECT_BASE + 10'(4 * c), 32'(24 + c % 10));
      clear_hits();
      for (int i = 0; i < 10; i++)
         fire_gen(i);
      for (int c = 0; c < 22; c++)
         `CHK("routed pulse", 1, per_gen_model_inst.hits[c])
   endtask

   task automatic t_soft;
      wr(per_pkg::CHANNEL_SOURCE_SELECT_BASE + 10'h00C, 32'h00000118);
      wr(per_pkg::CHANNEL_SOURCE_SELECT_BASE + 10'h010, 32'h00000018);
      clear_hits();
      fire_gen(0);
      `CHK("soft ignores gen", 0, per_gen_model_inst.hits[3])
      `CHK("gen drives chan", 1, per_gen_model_inst.hits[4])
      wr(per_pkg::SWEVT_OFS, 32'h00000018);
      wait_cyc(4);
      `CHK("soft event", 1, per_gen_model_inst.hits[3])
      `CHK("soft needs select", 1, per_gen_model_inst.hits[4])
   endtask

   task automatic t_none;
      wr(per_pkg::CHANNEL_SOURCE_SELECT_BASE + 10'h014, 32'h00000022);
      wr(per_pkg::CHANNEL_SOURCE_SELECT_BASE + 10'h018, 32'h0000003F);
      clear_hits();
      for (int i = 0; i < 10; i++)
         fire_gen(i);
      `CHK("select 34 silent", 0, per_gen_model_inst.hits[5])
      `CHK("select 63 silent", 0, per_gen_model_inst.hits[6])
   endtask

   task automatic t_shaper;
      int gl [3] = '{0, 16, 18};
      int ex [4] = '{0, 1, 1, 2};
      for (int i = 0; i < 3; i++)
         for (int m = 0; m < 4; m++)
         begin
            wr(per_pkg::EVS_BASE + 10'(4 * gl[i]), 32'(m));
            wr(per_pkg::CHANNEL_SOURCE_SELECT_BASE, 32'(gl[i]));
            clear_hits();
            pulse_lvl(gl[i], 8);
            `CHK("edge select", ex[m], per_gen_model_inst.hits[0])
         end
   endtask

   task automatic t_filter;
      wr(per_pkg::CHANNEL_SOURCE_SELECT_BASE, 32'h00000012);
      wr(per_pkg::EVS_BASE + 10'h048, 32'h00000007);
      clear_hits();
      pulse_lvl(18, 1);
      `CHK("glitch filtered", 0, per_gen_model_inst.hits[0])
      pulse_lvl(18, 8);
      `CHK("long pulse passes", 2, per_gen_model_inst.hits[0])
      wr(per_pkg::EVS_BASE + 10'h048, 32'h00000003);
      clear_hits();
      pulse_lvl(18, 1);
      `CHK("glitch unfiltered", 2, per_gen_model_inst.hits[0])
   endtask

   // ****************************************
   // Verdict and run control
   // ****************************************
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         summarize();
      end
   end

   initial
   begin
      wait_cyc(5);
      rstn <= 1'b1;
      t_regs();
      t_reset();
      t_route();
      t_soft();
      t_none();
      t_shaper();
      t_filter();
      summarize();
   end
endmodule

`default_nettype wire
